//--- verilog/cpmc_ctrl.sv
// Power mode and status mode controller, top level.
// Assumes pipeline, interrupt unit and bus give synchronous levels.
//
// Operation
// RL1: Full speed by default and after reset.
// RL2: Full speed: core and bus clocks equal.
// RL3: Standby: wait bus idle, stop core clocks.
// RL4: Standby keeps peripherals and DMA running.
// RL5: Any interrupt wakes standby to full speed.
// RL6: Suspend: self-refresh, bus idle, stop clocks.
// RL7: Suspend keeps state, only clockless peripherals.
// RL8: Accepted interrupt returns suspend to full speed.
// RL9: Hibernate stops all clocks, keeps state.
// RL10: Hibernate wakes on power, carrier, alarm.
// RL11: Always-on 32 kHz logic runs in hibernate.
// RL12: Kernel wide bit: wide opcodes, extended vector.
// RL13: Supervisor wide bit: wide opcodes, extended vector.
// RL14: User wide bit; clear means 32-bit addresses.
// RL15: Software keeps byte order flip at zero.
// RL16: Reset and NMI set boot vector select.
// RL17: Boot select set: boot region vectors.
// RL18: Boot select clear: kernel region vectors.
// RL19: Override: store writes parity error value.
// RL20: Override: fill writes parity error value.
// RL21: Trap disable bit suppresses parity exception.
// RL22: Gate clear blocks all but reset, NMI.
// RL23: Encoded power state, only documented transitions.
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
module cpmc_ctrl
   import cpmc_pkg::*;
#(
   parameter int RTC_DIV = CPMC_RTC_DIV // Cycles per 32 kHz tick.
) (
   input wire logic clk_sys, // System clock, 20 MHz.
   input wire logic rst_n, // Synchronous reset, active low.
   input wire logic [3:0] addr, // Register byte address.
   input wire logic [31:0] wdata, // Write data.
   input wire logic wr, // Write strobe.
   input wire logic rd, // Read strobe.
   output logic [31:0] rdata_q, // Read data, cycle after rd.
   input wire logic standby_wb, // Standby instruction left writeback.
   input wire logic suspend_wb, // Suspend instruction left writeback.
   input wire logic hibernate_wb, // Hibernate instruction left writeback.
   input wire logic sys_bus_idle, // Internal system bus is idle.
   input wire logic irq_req, // Any maskable interrupt pending.
   input wire logic nmi, // Non-maskable interrupt.
   input wire logic power_pin, // Power switch asserted.
   input wire logic carrier_detect_pin, // Carrier detect asserted.
   input wire logic alarm_timer, // Alarm timer interrupt.
   input wire logic parity_err, // Cache parity error seen.
   input wire logic [7:0] store_par, // Parity computed on a store.
   input wire logic [7:0] fill_par, // Parity computed on a fill.
   output logic core_clk_run_q, // Core clock runs; low holds it high.
   output logic peripheral_clk_run_q, // Peripheral clock runs.
   output logic bus_clk_out_run_q, // Bus clock output runs.
   output logic self_refresh_req_q, // DRAM self-refresh request.
   output logic [2:0] power_state_q, // Encoded power state.
   output logic irq_taken_q, // Interrupt accepted, one cycle later.
   output logic parity_exc_q, // Parity exception, one cycle later.
   output logic [63:0] miss_vec_q, // TLB mismatch vector.
   output logic [63:0] comm_vec_q, // Common exception vector.
   output logic [2:0] wide_en_q, // Wide opcode enable per level.
   output logic [2:0] ext_vec_q, // Extended vector use per level.
   output logic [7:0] dpar_q, // Data cache parity.
   output logic [7:0] ipar_q // Instruction cache parity.
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   cpmc_state_t state_q; // Current power state.
   cpmc_state_t state_d; // Next power state.
   logic [7:0] mode_q; // Mode bits register.
   logic [7:0] mode_d; // Next mode bits.
   logic [7:0] perr_q; // Parity error register.
   logic rtc_tick; // Always-on 32 kHz enable.
   logic wake_lat_q; // Hibernate wake event caught.
   logic hib_event; // Any hibernate wake source.
   logic irq_accept; // Interrupt passes the gate.
   logic wr_mode; // Write to the mode register.
   logic wr_perr; // Write to the parity error register.
   logic [31:0] rd_sel; // Read data selection.
   logic core_run; // Core clocks wanted.
   logic periph_run; // Peripheral clock wanted.
   logic bus_run; // Bus output clock wanted.
   logic sref; // Self-refresh wanted.

   cpmc_mode_if mi (); // Mode bits for the decoder.

   // ------------------------------------------------------------
   // Always-on tick
   // ------------------------------------------------------------
   // The divider is never gated, so wake detection works in hibernate.
   cpmc_rtc_div #(
      .DIV(RTC_DIV)
   ) u_div (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .tick(rtc_tick) // RL11
   );

   // ------------------------------------------------------------
   // Interrupt gating
   // ------------------------------------------------------------
   // NMI bypasses the gate; reset is handled by rst_n itself.
   assign irq_accept = (irq_req & mode_q[CPMC_B_IRQ_GATE]) | nmi; // RL22

   // Wake sources for hibernate, latched on any cycle, acted on at the always-on tick.
   assign hib_event = power_pin | carrier_detect_pin | alarm_timer; // RL10

   // ------------------------------------------------------------
   // Register decode
   // ------------------------------------------------------------
   assign wr_mode = wr & (addr == CPMC_REG_MODE);
   assign wr_perr = wr & (addr == CPMC_REG_PERR);

   // Unmapped addresses read as zero.
   assign rd_sel = (addr == CPMC_REG_MODE) ? {24'h000000, mode_q} :
                   (addr == CPMC_REG_POWER) ?
                      {27'h0000000, self_refresh_req_q, 1'b0, state_q} :
                   (addr == CPMC_REG_PERR) ? {24'h000000, perr_q} :
                   32'h00000000;

   // Software writes the mode bits, but NMI setting boot select
   // wins over a clearing write in the same cycle.
   // The flip bit is kept as written; software must hold it at zero.
   always_comb begin
      mode_d = mode_q;
      if (wr_mode) begin
         mode_d = wdata[7:0]; // RL15
      end
      if (nmi) begin
         mode_d[CPMC_B_BOOTVEC] = 1'b1; // RL16
      end
   end

   // ------------------------------------------------------------
   // Power state machine
   // ------------------------------------------------------------
   // Only paths into and back out of each low-power state exist.
   always_comb begin
      state_d = state_q;
      case (state_q)
         CPMC_FULL: begin
            if (hibernate_wb) begin
               state_d = CPMC_HIBERNATE; // RL9
            end else if (suspend_wb) begin
               state_d = CPMC_SP_SREF; // RL6
            end else if (standby_wb) begin
               state_d = CPMC_SB_WAIT; // RL3
            end
         end
         CPMC_SB_WAIT: begin
            if (sys_bus_idle) begin
               state_d = CPMC_STANDBY; // RL3
            end
         end
         CPMC_STANDBY: begin
            // Any interrupt, masked or not, ends standby.
            if (irq_req | nmi) begin
               state_d = CPMC_FULL; // RL5
            end
         end
         CPMC_SP_SREF: begin
            state_d = CPMC_SP_WAIT; // RL6
         end
         CPMC_SP_WAIT: begin
            if (sys_bus_idle) begin
               state_d = CPMC_SUSPEND; // RL6
            end
         end
         CPMC_SUSPEND: begin
            if (irq_accept) begin
               state_d = CPMC_FULL; // RL8
            end
         end
         CPMC_HIBERNATE: begin
            if (wake_lat_q & rtc_tick) begin
               state_d = CPMC_FULL; // RL10
            end
         end
         default: begin
            state_d = CPMC_FULL; // RL23
         end
      endcase
   end

   // ------------------------------------------------------------
   // Clock enables per state
   // ------------------------------------------------------------
   // Core clocks stop in every low state; the timer and interrupt
   // clocks are not gated here at all.
   assign core_run = (state_d == CPMC_FULL) | (state_d == CPMC_SB_WAIT) |
                     (state_d == CPMC_SP_SREF) | (state_d == CPMC_SP_WAIT); // RL3
   // Standby keeps peripherals and DMA clocked.
   assign periph_run = (state_d != CPMC_SUSPEND) &
                       (state_d != CPMC_HIBERNATE); // RL4 RL7
   // Bus output runs with the core in full speed, off in hibernate.
   assign bus_run = (state_d != CPMC_HIBERNATE); // RL2 RL9
   // Refresh is asked before waiting for the bus, held until wake.
   assign sref = (state_d == CPMC_SP_SREF) | (state_d == CPMC_SP_WAIT) |
                 (state_d == CPMC_SUSPEND); // RL6

   // ------------------------------------------------------------
   // State and output registers
   // ------------------------------------------------------------
   // Register and cache contents live elsewhere; stopping clocks
   // rather than resetting keeps them.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_q <= CPMC_FULL; // RL1
         core_clk_run_q <= 1'b1;
         peripheral_clk_run_q <= 1'b1;
         bus_clk_out_run_q <= 1'b1;
         self_refresh_req_q <= 1'b0;
         power_state_q <= 3'h0;
      end else begin
         state_q <= state_d; // RL23
         core_clk_run_q <= core_run;
         peripheral_clk_run_q <= periph_run; // RL7
         bus_clk_out_run_q <= bus_run;
         self_refresh_req_q <= sref;
         power_state_q <= state_d;
      end
   end

   // Catch a wake event between ticks; clear on leaving hibernate.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wake_lat_q <= 1'b0;
      end else if (state_q != CPMC_HIBERNATE) begin
         wake_lat_q <= 1'b0;
      end else if (hib_event) begin
         wake_lat_q <= 1'b1; // RL10
      end
   end

   // ------------------------------------------------------------
   // Mode registers and event outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         mode_q <= CPMC_MODE_RST; // RL16
         perr_q <= CPMC_PERR_RST;
         irq_taken_q <= 1'b0;
         parity_exc_q <= 1'b0;
         rdata_q <= 32'h00000000;
      end else begin
         mode_q <= mode_d;
         perr_q <= wr_perr ? wdata[7:0] : perr_q;
         irq_taken_q <= irq_accept; // RL22
         parity_exc_q <= parity_err & ~mode_q[CPMC_B_PTD]; // RL21
         rdata_q <= rd ? rd_sel : 32'h00000000;
      end
   end

   // ------------------------------------------------------------
   // Decoder hookup
   // ------------------------------------------------------------
   assign mi.kwide = mode_q[CPMC_B_KWIDE]; // RL12
   assign mi.swide = mode_q[CPMC_B_SWIDE]; // RL13
   assign mi.uwide = mode_q[CPMC_B_UWIDE]; // RL14
   assign mi.bootvec = mode_q[CPMC_B_BOOTVEC];
   assign mi.povr = mode_q[CPMC_B_POVR];
   assign mi.perr = perr_q;

   cpmc_decode u_dec (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .mi(mi),
      .store_par(store_par),
      .fill_par(fill_par),
      .miss_vec_q(miss_vec_q),
      .comm_vec_q(comm_vec_q),
      .wide_en_q(wide_en_q),
      .ext_vec_q(ext_vec_q),
      .dpar_q(dpar_q),
      .ipar_q(ipar_q)
   );

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   sequence s_sb_enter;
      (state_q == CPMC_FULL) && standby_wb && !suspend_wb && !hibernate_wb;
   endsequence

   sequence s_sp_enter;
      (state_q == CPMC_FULL) && suspend_wb && !hibernate_wb;
   endsequence

   a_reset_full_speed: assert property (@(posedge clk_sys) // RL1
      !rst_n |=> (state_q == CPMC_FULL) && core_clk_run_q)
      else $error("not full speed after reset");

   a_standby_idle_wait: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL3
      s_sb_enter ##1 !sys_bus_idle |=> core_clk_run_q)
      else $error("core clock stopped before bus idle");

   a_standby_periph_on: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL4
      (state_q == CPMC_STANDBY) |-> peripheral_clk_run_q && bus_clk_out_run_q)
      else $error("peripheral clock stopped in standby");

   a_standby_wake: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL5
      (state_q == CPMC_STANDBY) && irq_req |=> (state_q == CPMC_FULL) && core_clk_run_q)
      else $error("standby not left on interrupt");

   a_suspend_sref_first: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL6
      s_sp_enter |=> self_refresh_req_q && core_clk_run_q ##1 self_refresh_req_q)
      else $error("self-refresh not requested first");

   a_suspend_clocks: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL7
      (state_q == CPMC_SUSPEND) |-> !peripheral_clk_run_q && bus_clk_out_run_q)
      else $error("suspend clocks wrong");

   a_suspend_wake: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL8
      (state_q == CPMC_SUSPEND) && irq_accept |=> (state_q == CPMC_FULL))
      else $error("suspend not left on accepted interrupt");

   a_suspend_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL23
      (state_q == CPMC_SUSPEND) && !irq_accept |=> (state_q == CPMC_SUSPEND))
      else $error("suspend left without interrupt");

   a_hib_clocks_off: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL9
      (state_q == CPMC_HIBERNATE) |-> !bus_clk_out_run_q && !peripheral_clk_run_q)
      else $error("clock running in hibernate");

   a_hib_wake: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL10
      (state_q == CPMC_HIBERNATE) && power_pin |-> ##[1:1000] (state_q == CPMC_FULL))
      else $error("hibernate not left on power pin");

   a_bootvec_nmi: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL16
      nmi |=> mode_q[CPMC_B_BOOTVEC])
      else $error("boot select not set by nmi");

   a_irq_gate_block: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL22
      !mode_q[CPMC_B_IRQ_GATE] && !nmi |=> !irq_taken_q)
      else $error("interrupt taken while gated");

   a_parity_trap_off: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL21
      mode_q[CPMC_B_PTD] |=> !parity_exc_q)
      else $error("parity exception while disabled");

endmodule

//--- verilog/cpmc_pkg.sv
// Shared constants and types for the power and mode controller.
// Assumes a single 20 MHz system clock and synchronous inputs.
package cpmc_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CPMC_CLK_HZ = 20_000_000; // System clock rate.
   localparam int CPMC_FULL_MHZ = 33; // Nominal full speed core rate.
   localparam int CPMC_RTC_HZ = 32_768; // Always-on oscillator rate.
   // Cycles per always-on tick, rounded down.
   localparam int CPMC_RTC_DIV = CPMC_CLK_HZ / CPMC_RTC_HZ;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [3:0] CPMC_REG_MODE = 4'h0; // Mode bits.
   localparam logic [3:0] CPMC_REG_POWER = 4'h4; // Power status.
   localparam logic [3:0] CPMC_REG_PERR = 4'h8; // Parity error value.

   // Mode register fields.
   localparam int CPMC_B_IRQ_GATE = 0;
   localparam int CPMC_B_KWIDE = 1;
   localparam int CPMC_B_SWIDE = 2;
   localparam int CPMC_B_UWIDE = 3;
   localparam int CPMC_B_FLIP = 4;
   localparam int CPMC_B_BOOTVEC = 5;
   localparam int CPMC_B_POVR = 6;
   localparam int CPMC_B_PTD = 7;
   localparam logic [7:0] CPMC_MODE_RST = 8'h20; // Boot vectors on.
   localparam logic [7:0] CPMC_PERR_RST = 8'h00;

   // ------------------------------------------------------------
   // Exception vectors
   // ------------------------------------------------------------
   localparam logic [63:0] CPMC_VEC_MISS_BOOT = 64'hFFFF_FFFF_BFC0_0200;
   localparam logic [63:0] CPMC_VEC_COMM_BOOT = 64'hFFFF_FFFF_BFC0_0380;
   localparam logic [63:0] CPMC_VEC_MISS_NORM = 64'hFFFF_FFFF_8000_0000;
   localparam logic [63:0] CPMC_VEC_COMM_NORM = 64'hFFFF_FFFF_8000_0180;

   // Power states; the status register shows the state index.
   typedef enum logic [2:0] {
      CPMC_FULL, CPMC_SB_WAIT, CPMC_STANDBY, CPMC_SP_SREF,
      CPMC_SP_WAIT, CPMC_SUSPEND, CPMC_HIBERNATE
   } cpmc_state_t;

endpackage

//--- verilog/cpmc_mode_if.sv
// Mode bits passed from the controller to its vector decoder.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ns
interface cpmc_mode_if;
   logic kwide; // Kernel wide addressing.
   logic swide; // Supervisor wide addressing.
   logic uwide; // User wide addressing.
   logic bootvec; // Boot vector select.
   logic povr; // Parity override.
   logic [7:0] perr; // Parity error register value.
   modport ctl (output kwide, swide, uwide, bootvec, povr, perr);
   modport dec (input kwide, swide, uwide, bootvec, povr, perr);
endinterface

//--- verilog/cpmc_rtc_div.sv
// Divider that makes the always-on 32 kHz tick as an enable.
// Assumes one system clock; the tick is one cycle wide.
`timescale 1ns/1ns
module cpmc_rtc_div #(
   parameter int DIV = 610 // System cycles per tick.
) (
   input wire logic clk_sys, // System clock.
   input wire logic rst_n, // Synchronous reset, active low.
   output logic tick // One-cycle always-on tick.
);
   logic [15:0] cnt_q; // Cycle counter.
   logic wrap; // Counter reached the end.

   assign wrap = (cnt_q == 16'(DIV - 1));

   // ------------------------------------------------------------
   // Counter; it never stops, so wake events stay visible.
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cnt_q <= 16'h0000;
         tick <= 1'b0;
      end else begin
         cnt_q <= wrap ? 16'h0000 : cnt_q + 16'h0001;
         tick <= wrap;
      end
   end
endmodule

//--- verilog/cpmc_decode.sv
// Vector, opcode and parity selection from the mode bits.
// Assumes mode bits arrive over the mode interface.
`timescale 1ns/1ns
module cpmc_decode
   import cpmc_pkg::*;
(
   input wire logic clk_sys, // System clock.
   input wire logic rst_n, // Synchronous reset, active low.
   cpmc_mode_if.dec mi, // Mode bits.
   input wire logic [7:0] store_par, // Parity computed on a store.
   input wire logic [7:0] fill_par, // Parity computed on a fill.
   output logic [63:0] miss_vec_q, // TLB mismatch vector.
   output logic [63:0] comm_vec_q, // Common exception vector.
   output logic [2:0] wide_en_q, // Wide opcodes: user, super, kernel.
   output logic [2:0] ext_vec_q, // Extended mismatch vector use.
   output logic [7:0] dpar_q, // Parity into the data cache.
   output logic [7:0] ipar_q // Parity into the instruction cache.
);
   logic [63:0] miss_sel; // Selected mismatch vector.
   logic [63:0] comm_sel; // Selected common vector.
   logic [2:0] wide_sel; // Per privilege level enable.

   assign miss_sel = mi.bootvec ? CPMC_VEC_MISS_BOOT : CPMC_VEC_MISS_NORM; // RL17 RL18
   assign comm_sel = mi.bootvec ? CPMC_VEC_COMM_BOOT : CPMC_VEC_COMM_NORM; // RL17 RL18
   // Clear user bit leaves the older opcodes and 32-bit addresses.
   assign wide_sel = {mi.uwide, mi.swide, mi.kwide}; // RL12 RL13 RL14

   // ------------------------------------------------------------
   // Registered outputs.
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         miss_vec_q <= CPMC_VEC_MISS_BOOT;
         comm_vec_q <= CPMC_VEC_COMM_BOOT;
         wide_en_q <= 3'h0;
         ext_vec_q <= 3'h0;
         dpar_q <= 8'h00;
         ipar_q <= 8'h00;
      end else begin
         miss_vec_q <= miss_sel;
         comm_vec_q <= comm_sel;
         wide_en_q <= wide_sel;
         ext_vec_q <= wide_sel;
         dpar_q <= mi.povr ? mi.perr : store_par; // RL19
         ipar_q <= mi.povr ? mi.perr : fill_par; // RL20
      end
   end

   a_vec_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
      mi.bootvec |=> (miss_vec_q == CPMC_VEC_MISS_BOOT)) // RL17
      else $error("mismatch vector not at boot address");
   a_par_override: assert property (@(posedge clk_sys) disable iff (!rst_n)
      mi.povr |=> (dpar_q == $past(mi.perr))) // RL19
      else $error("store parity not overridden");
endmodule

//--- tb/cpmc_bus_model.sv
// Far side model: internal bus traffic seen by the power controller.
// Assumes the bench pulses start together with a low-power request.
`timescale 1ns/1ns
module cpmc_bus_model (
   input wire logic clk_sys, // System clock.
   input wire logic rst_n, // Synchronous reset, active low.
   input wire logic start, // Begin a burst of bus traffic.
   input wire logic [3:0] hold, // Busy cycles of that burst.
   output logic sys_bus_idle // Internal bus idle.
);
   logic [3:0] busy_q; // Busy cycles still to run.

   // Counts the burst down; a long hold makes the controller wait.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) busy_q <= 4'h0;
      else if (start) busy_q <= hold;
      else if (busy_q != 4'h0) busy_q <= busy_q - 4'h1;
   end

   // Idle only once the burst has drained.
   assign sys_bus_idle = (busy_q == 4'h0);
endmodule

//--- tb/cpu_power_and_mode_control_test.sv
// Self-checking bench for the power and mode controller.
// Assumes the bus model on the far side and a short always-on divider.
`timescale 1ns/1ns
module cpu_power_and_mode_control_test
   import cpmc_pkg::*;
;
   localparam int RTC = 4; // Short divider keeps hibernate exits brief.
   logic clk_sys, rst_n, wr, rd, standby_wb, suspend_wb, hibernate_wb, irq_req, nmi;
   logic power_pin, carrier_detect_pin, alarm_timer, parity_err, sys_bus_idle, bus_start;
   logic core_clk_run_q, peripheral_clk_run_q, bus_clk_out_run_q, self_refresh_req_q;
   logic irq_taken_q, parity_exc_q;
   logic [2:0] power_state_q, wide_en_q, ext_vec_q;
   logic [3:0] addr, bus_hold;
   logic [7:0] store_par, fill_par, dpar_q, ipar_q, perr, m;
   logic [15:0] seed; // Random source state.
   logic [31:0] wdata, rdata_q;
   logic [63:0] miss_vec_q, comm_vec_q;
   int n_mismatch, tests_run;

   cpmc_bus_model bus_u (.clk_sys, .rst_n, .start(bus_start), .hold(bus_hold),
      .sys_bus_idle);
   cpmc_ctrl #(.RTC_DIV(RTC)) dut_u (.clk_sys, .rst_n, .addr, .wdata, .wr, .rd, .rdata_q,
      .standby_wb, .suspend_wb, .hibernate_wb, .sys_bus_idle, .irq_req, .nmi, .power_pin,
      .carrier_detect_pin, .alarm_timer, .parity_err, .store_par, .fill_par,
      .core_clk_run_q, .peripheral_clk_run_q, .bus_clk_out_run_q, .self_refresh_req_q,
      .power_state_q, .irq_taken_q, .parity_exc_q, .miss_vec_q, .comm_vec_q,
      .wide_en_q, .ext_vec_q, .dpar_q, .ipar_q);

   // ----------------
   // Helpers
   // ----------------
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Expected vector pair for a boot vector select value.
   function automatic logic [127:0] exp_vec(input logic b);
      return b ? {CPMC_VEC_MISS_BOOT, CPMC_VEC_COMM_BOOT}
               : {CPMC_VEC_MISS_NORM, CPMC_VEC_COMM_NORM};
   endfunction

   task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= 32'(d);
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe.
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1;
      chk(rdata_q, exp);
   endtask

   // One-cycle {hibernate, suspend, standby} pulse with bus traffic.
   task automatic wb(input logic [2:0] k);
      seed = lfsr(seed);
      @(posedge clk_sys);
      {hibernate_wb, suspend_wb, standby_wb} <= k;
      bus_start <= 1'b1;
      bus_hold <= seed[3:0] | 4'h1;
      @(posedge clk_sys);
      {hibernate_wb, suspend_wb, standby_wb, bus_start} <= 4'h0;
      #1;
   endtask

   // Bounded wait for a power state, then a compare.
   task automatic wait_st(input logic [2:0] s, input int lim);
      for (int i = 0; i < lim && power_state_q !== s; i++) begin
         @(posedge clk_sys);
         #1;
      end
      chk(power_state_q, s);
   endtask

   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // ----------------
   // Clock, watchdog and main sequence
   // ----------------
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // The run needs under a thousand cycles; this catches a hang.
   initial begin
      repeat (5000) @(posedge clk_sys);
      n_mismatch++;
      report_and_stop;
   end

   initial begin
      {rst_n, wr, rd, standby_wb, suspend_wb, hibernate_wb, irq_req, nmi} = 8'h00;
      {power_pin, carrier_detect_pin, alarm_timer, parity_err, bus_start} = 5'h00;
      {addr, bus_hold, store_par, fill_par, wdata} = 56'h0;
      seed = 16'h89DB;
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      #1;
      chk({power_state_q, core_clk_run_q, peripheral_clk_run_q, bus_clk_out_run_q}, 6'h07);
      chk({core_clk_run_q, bus_clk_out_run_q}, 2'h3);
      chk({miss_vec_q, comm_vec_q}, exp_vec(1'b1));
      rd_chk(CPMC_REG_MODE, 32'h20);
      rd_chk(4'hC, 32'h0);
      perr = seed[7:0];
      wr_reg(CPMC_REG_PERR, perr);
      // All bits, none, then random; byte order flip kept clear.
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         m = (i == 0) ? 8'hEF : (i == 1) ? 8'h00 : seed[7:0] & 8'hEF;
         wr_reg(CPMC_REG_MODE, m);
         store_par <= seed[15:8];
         fill_par <= ~seed[15:8];
         @(posedge clk_sys);
         #1;
         chk(wide_en_q, m[3:1]);
         chk(ext_vec_q, m[3:1]);
         chk({miss_vec_q, comm_vec_q}, exp_vec(m[5]));
         chk(dpar_q, m[6] ? perr : store_par);
         chk(ipar_q, m[6] ? perr : fill_par);
         @(posedge clk_sys);
         {parity_err, irq_req} <= 2'h3;
         @(posedge clk_sys);
         {parity_err, irq_req} <= 2'h0;
         #1;
         chk(parity_exc_q, !m[7]);
         chk(irq_taken_q, m[0]);
         rd_chk(CPMC_REG_MODE, 32'(m));
      end
      // An NMI passes a closed gate and selects boot vectors.
      wr_reg(CPMC_REG_MODE, 8'h00);
      @(posedge clk_sys);
      nmi <= 1'b1;
      @(posedge clk_sys);
      nmi <= 1'b0;
      #1;
      chk(irq_taken_q, 1'b1);
      rd_chk(CPMC_REG_MODE, 32'h20);
      wr_reg(CPMC_REG_MODE, 8'h00);
      // Standby waits for the bus, keeps peripherals, wakes on a raw interrupt.
      wb(3'b001);
      chk({power_state_q, core_clk_run_q}, 4'h3);
      wait_st(3'h2, 20);
      chk({core_clk_run_q, peripheral_clk_run_q, bus_clk_out_run_q}, 3'h3);
      rd_chk(CPMC_REG_POWER, 32'h2);
      @(posedge clk_sys);
      irq_req <= 1'b1;
      @(posedge clk_sys);
      irq_req <= 1'b0;
      #1;
      chk({power_state_q, core_clk_run_q}, 4'h1);
      // Suspend ignores a gated interrupt until the gate opens.
      wb(3'b010);
      chk({power_state_q, self_refresh_req_q}, 4'h7);
      wait_st(3'h5, 20);
      chk({core_clk_run_q, peripheral_clk_run_q, bus_clk_out_run_q}, 3'h1);
      @(posedge clk_sys);
      irq_req <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
      chk({power_state_q, irq_taken_q}, 4'hA);
      wr_reg(CPMC_REG_MODE, 8'h01);
      wait_st(3'h0, 4);
      chk(self_refresh_req_q, 1'b0);
      irq_req <= 1'b0;
      // Hibernate exits on each of its three wake sources.
      for (int k = 0; k < 3; k++) begin
         wb(3'b100);
         chk({power_state_q, core_clk_run_q, peripheral_clk_run_q, bus_clk_out_run_q}, 6'h30);
         repeat (10) @(posedge clk_sys);
         #1;
         chk(power_state_q, 3'h6);
         @(posedge clk_sys);
         {power_pin, carrier_detect_pin, alarm_timer} <= 3'b001 << k;
         @(posedge clk_sys);
         {power_pin, carrier_detect_pin, alarm_timer} <= 3'b000;
         wait_st(3'h0, RTC + 3);
      end
      report_and_stop;
   end
endmodule
